/* logic/halfbit_ticker.sv */
module halfbit_ticker
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic restart_in,
    input wire logic [15:0] period_in,
    // Half-bit enable pulse
    output logic tick_out
);
    logic [15:0] count;

    // Pulse once every period_in plus one cycles
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || restart_in)
        begin
            count <= 16'h0000;
            tick_out <= 1'b0;
        end
        else if (count >= period_in)
        begin
            count <= 16'h0000;
            tick_out <= 1'b1;
        end
        else
        begin
            count <= count + 16'h0001;
            tick_out <= 1'b0;
        end
    end
endmodule

/* logic/lighting_manchester_uart.sv */
`include "manchester_regs.svh"

module line_sync
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Pin and polarity
    input wire logic pin_in,
    input wire logic invert_in,
    // Normalised level, idle high, and edge
    output logic level_out,
    output logic edge_out
);
    logic sync1, sync2, prev;

    // Two-stage synchroniser, then one more stage for edges
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            prev <= 1'b1;
        end
        else
        begin
            sync1 <= pin_in;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // Polarity and edge from settled stages only
    assign level_out = sync2 ^ invert_in;
    assign edge_out = sync2 ^ prev;
endmodule

/* logic/lighting_manchester_uart_top.sv */
`include "manchester_regs.svh"

module lighting_manchester_uart
    import manchester_pkg::*;
#(
    parameter logic [15:0] HALFBIT_CYCLES = 16'(`HALF_BIT_CYCLES)
)
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // Configuration
    input wire logic [3:0] MODE_IN,
    input wire logic TRANSMITTER_ENABLE_IN,
    input wire logic RECEIVER_ENABLE_IN,
    input wire logic [1:0] STOP_BIT_SELECT_IN,
    input wire logic TRANSMIT_POLARITY_IN,
    input wire logic RECEIVE_POLARITY_IN,
    input wire logic RATE_DETECT_ENABLE_IN,
    input wire logic [15:0] BAUD_DIVISOR_IN,
    input wire logic [7:0] FRAME_WAIT_HALFBITS_IN,
    input wire logic [7:0] FORWARD_THRESHOLD_HALFBITS_IN,
    // Transmit side
    input wire logic [7:0] TRANSMIT_BUFFER_IN,
    input wire logic TRANSMIT_WRITE_IN,
    input wire logic TRANSMIT_EMPTY_FLUSH_IN,
    output logic TRANSMIT_READY_FLAG_OUT,
    output logic SHIFT_EMPTY_FLAG_OUT,
    // Receive side
    input wire logic RECEIVE_READ_IN,
    output logic [7:0] RECEIVE_BUFFER_OUT,
    output logic RECEIVE_READY_FLAG_OUT,
    output logic FRAMING_ERROR_FLAG_OUT,
    output logic FORWARD_FRAME_MARKER_OUT,
    output logic RATE_DETECT_OVERFLOW_OUT,
    // Bus pins
    input wire logic RX_PIN_IN,
    output logic TX_PIN_OUT
);
    tx_state_t tx_state;
    rx_state_t rx_state;
    logic ctrl, gear, enabled, tick, tx_go, tx_norm, half, tx_done;
    logic tsr_loaded, hold_full, wait_on, wait_go, rx_level, rx_edge;
    logic rx_fwd, rx_done, stop_bad, st_req, st_fe, take, tx_active;
    logic [7:0] tsr, hold, idle_hb, wait_cnt, rx_shift, st_data;
    logic [2:0] tx_bits, stop_left, rx_bits;
    logic [15:0] meas, period, baud_p, meas_max;
    logic [17:0] since, mid_min, end_at, stop_at;

    ////////////////////////////////////////////////////////////////////////
    // Role decode and timing
    assign ctrl = (MODE_IN == `MODE_CONTROLLER);
    assign gear = (MODE_IN == `MODE_GEAR);
    assign enabled = (ctrl || gear) && TRANSMITTER_ENABLE_IN
        && RECEIVER_ENABLE_IN;
    assign tx_active = (tx_state == TX_START) || (tx_state == TX_DATA);

    // Half-bit pulses from the baud divisor, realigned at frame start
    halfbit_ticker u_ticker
    (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .restart_in(tx_go),
        .period_in(BAUD_DIVISOR_IN),
        .tick_out(tick)
    );

    // Receive pin through synchroniser and polarity
    line_sync u_sync
    (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .pin_in(RX_PIN_IN),
        .invert_in(RECEIVE_POLARITY_IN),
        .level_out(rx_level),
        .edge_out(rx_edge)
    );

    // Receive thresholds in cycles, from one half-bit period
    assign baud_p = BAUD_DIVISOR_IN + 16'h0001;
    assign mid_min = {2'h0, period} + {3'h0, period[15:1]};
    assign end_at = {1'h0, period, 1'h0} + {3'h0, period[15:1]};
    assign stop_at = {period, 2'h0};
    assign meas_max = {HALFBIT_CYCLES[14:0], 1'b0};

    // Number of idle half bits after the last byte
    function automatic logic [2:0] stop_halfbits(input logic [1:0] sel);
        case (sel)
            2'h0: stop_halfbits = 3'h2;
            2'h1: stop_halfbits = 3'h3;
            default: stop_halfbits = 3'h4;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    assign wait_go = wait_on && (wait_cnt == 8'h00);
    assign tx_go = enabled && (tx_state == TX_IDLE) && tsr_loaded
        && !TRANSMIT_EMPTY_FLUSH_IN
        && (gear ? wait_go : (!wait_on && rx_state == RX_IDLE));
    assign TRANSMIT_READY_FLAG_OUT = !hold_full;
    assign SHIFT_EMPTY_FLAG_OUT = !tsr_loaded;

    // Buffer, shifter and frame sequencing
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            tx_state <= TX_IDLE;
            half <= 1'b0;
            tx_bits <= 3'h0;
            stop_left <= 3'h0;
            tsr <= 8'h00;
            tsr_loaded <= 1'b0;
            hold <= 8'h00;
            hold_full <= 1'b0;
            tx_done <= 1'b0;
        end
        else
        begin
            tx_done <= 1'b0;
            if (TRANSMIT_EMPTY_FLUSH_IN && !tx_active)
            begin
                hold_full <= 1'b0;
                tsr_loaded <= 1'b0;
            end
            else if (hold_full && !tsr_loaded)
            begin
                tsr <= hold;
                tsr_loaded <= 1'b1;
                hold_full <= 1'b0;
            end
            if (TRANSMIT_WRITE_IN && !hold_full)
            begin
                hold <= TRANSMIT_BUFFER_IN;
                hold_full <= 1'b1;
            end
            case (tx_state)
                TX_IDLE:
                    if (tx_go)
                    begin
                        tx_state <= TX_START;
                        half <= 1'b0;
                        tx_bits <= 3'h0;
                    end
                TX_START:
                    if (tick)
                    begin
                        half <= !half;
                        if (half)
                            tx_state <= TX_DATA;
                    end
                TX_DATA:
                    if (tick)
                    begin
                        half <= !half;
                        if (half)
                        begin
                            tx_bits <= tx_bits + 3'h1;
                            tsr <= {tsr[6:0], 1'b0};
                            if (tx_bits == 3'h7 && hold_full)
                            begin
                                tsr <= hold;
                                hold_full <= 1'b0;
                            end
                            else if (tx_bits == 3'h7)
                            begin
                                tsr_loaded <= 1'b0;
                                stop_left <= stop_halfbits(STOP_BIT_SELECT_IN);
                                tx_state <= TX_STOP;
                            end
                        end
                    end
                TX_STOP:
                    if (tick)
                    begin
                        stop_left <= stop_left - 3'h1;
                        if (stop_left == 3'h1)
                        begin
                            tx_state <= TX_IDLE;
                            tx_done <= 1'b1;
                        end
                    end
                default:
                    tx_state <= TX_IDLE;
            endcase
        end
    end

    // Line level: low then high is a one, idle high
    always_comb
    begin
        case (tx_state)
            TX_START: tx_norm = half;
            TX_DATA: tx_norm = half ? tsr[7] : !tsr[7];
            default: tx_norm = 1'b1;
        endcase
    end

    // Registered pin with transmit polarity
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            TX_PIN_OUT <= 1'b1;
        else
            TX_PIN_OUT <= tx_norm ^ TRANSMIT_POLARITY_IN;
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame spacing: idle count and wait timer
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            idle_hb <= `IDLE_SATURATED;
        else if (rx_done || tx_done)
            idle_hb <= 8'h00;
        else if (tick && rx_state == RX_IDLE && tx_state == TX_IDLE
            && idle_hb != `IDLE_SATURATED)
            idle_hb <= idle_hb + 8'h01;
    end

    // Wait before the next transmission, in half bits
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN || !enabled)
        begin
            wait_on <= 1'b0;
            wait_cnt <= 8'h00;
        end
        else if ((ctrl && (rx_state != RX_IDLE || rx_done || tx_done))
            || (gear && rx_done && rx_fwd))
        begin
            wait_on <= 1'b1;
            wait_cnt <= FRAME_WAIT_HALFBITS_IN;
        end
        else if (wait_go)
            wait_on <= 1'b0;
        else if (wait_on && tick)
            wait_cnt <= wait_cnt - 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN || !enabled)
        begin
            rx_state <= RX_IDLE;
            meas <= 16'h0000;
            period <= 16'h0000;
            since <= 18'h00000;
            rx_shift <= 8'h00;
            rx_bits <= 3'h0;
            stop_bad <= 1'b0;
            rx_fwd <= 1'b0;
            rx_done <= 1'b0;
            st_req <= 1'b0;
            st_data <= 8'h00;
            st_fe <= 1'b0;
            RATE_DETECT_OVERFLOW_OUT <= 1'b0;
        end
        else
        begin
            st_req <= 1'b0;
            rx_done <= 1'b0;
            case (rx_state)
                RX_IDLE:
                    if (rx_edge && !rx_level)
                    begin
                        rx_state <= RX_START;
                        meas <= 16'h0000;
                        rx_fwd <= gear
                            ? (idle_hb > FORWARD_THRESHOLD_HALFBITS_IN)
                            : (idle_hb >= FORWARD_THRESHOLD_HALFBITS_IN);
                    end
                RX_START:
                    if (rx_edge)
                    begin
                        period <= RATE_DETECT_ENABLE_IN ? meas : baud_p;
                        rx_shift <= 8'h00;
                        since <= 18'h00000;
                        rx_bits <= 3'h0;
                        rx_state <= RX_DATA;
                    end
                    else if (meas >= meas_max)
                    begin
                        rx_state <= RX_IDLE;
                        if (RATE_DETECT_ENABLE_IN)
                            RATE_DETECT_OVERFLOW_OUT <= 1'b1;
                    end
                    else
                        meas <= meas + 16'h0001;
                RX_DATA:
                begin
                    since <= since + 18'h00001;
                    if (rx_edge && since >= mid_min)
                    begin
                        since <= 18'h00000;
                        rx_shift <= {rx_shift[6:0], rx_level};
                        rx_bits <= rx_bits + 3'h1;
                        if (rx_bits == 3'h7)
                        begin
                            st_req <= 1'b1;
                            st_data <= {rx_shift[6:0], rx_level};
                            st_fe <= 1'b0;
                        end
                    end
                    else if (since >= end_at)
                    begin
                        rx_state <= RX_STOP;
                        stop_bad <= !rx_level;
                        if (rx_bits != 3'h0)
                        begin
                            st_req <= 1'b1;
                            st_data <= rx_shift;
                            st_fe <= 1'b1;
                        end
                    end
                end
                RX_STOP:
                begin
                    since <= since + 18'h00001;
                    if (rx_edge && STOP_BIT_SELECT_IN == `STOP_TWO)
                        stop_bad <= 1'b1;
                    if (since >= stop_at)
                    begin
                        rx_state <= RX_IDLE;
                        rx_done <= 1'b1;
                        if (stop_bad || (STOP_BIT_SELECT_IN == `STOP_TWO
                            && (rx_edge || !rx_level)))
                        begin
                            st_req <= 1'b1;
                            st_data <= `NULL_BYTE;
                            st_fe <= 1'b1;
                        end
                    end
                end
                default:
                    rx_state <= RX_IDLE;
            endcase
        end
    end

    // Receive holding register; a store beats a read in the same cycle
    assign take = st_req && (ctrl || rx_fwd);
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            RECEIVE_BUFFER_OUT <= 8'h00;
            FRAMING_ERROR_FLAG_OUT <= 1'b0;
            FORWARD_FRAME_MARKER_OUT <= 1'b0;
            RECEIVE_READY_FLAG_OUT <= 1'b0;
        end
        else if (take)
        begin
            RECEIVE_BUFFER_OUT <= st_data;
            FRAMING_ERROR_FLAG_OUT <= st_fe;
            FORWARD_FRAME_MARKER_OUT <= ctrl && rx_fwd;
            RECEIVE_READY_FLAG_OUT <= 1'b1;
        end
        else if (RECEIVE_READ_IN)
            RECEIVE_READY_FLAG_OUT <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    idle_line_a: assert property (
        (tx_state == TX_IDLE || tx_state == TX_STOP)
        |=> TX_PIN_OUT == !$past(TRANSMIT_POLARITY_IN))
        else $error("line not idle outside data");
    mid_edge_a: assert property (
        (tx_state == TX_DATA && !half && tick) |=> tx_norm != $past(tx_norm))
        else $error("no mid-bit transition");
    msb_first_a: assert property (
        (tx_state == TX_DATA && half && tick && tx_bits != 3'h7)
        |=> tsr[7] == $past(tsr[6]))
        else $error("bits not shifted msb first");
    wait_holds_a: assert property (
        (ctrl && wait_on && wait_cnt != 8'h00 && tx_state == TX_IDLE)
        |=> tx_state == TX_IDLE)
        else $error("sent during frame wait");
    wait_restart_a: assert property (
        (ctrl && enabled && rx_done)
        |=> wait_on && wait_cnt == $past(FRAME_WAIT_HALFBITS_IN))
        else $error("wait not restarted by frame");
    flush_a: assert property (
        (TRANSMIT_EMPTY_FLUSH_IN && !tx_active) |=> SHIFT_EMPTY_FLAG_OUT)
        else $error("flush left shifter loaded");
    null_byte_a: assert property (
        (enabled && rx_state == RX_STOP && since >= stop_at && stop_bad
        && (ctrl || rx_fwd))
        |-> ##2 RECEIVE_BUFFER_OUT == `NULL_BYTE && FRAMING_ERROR_FLAG_OUT)
        else $error("bad stop not stored as null byte");
    partial_fe_a: assert property (
        (enabled && rx_state == RX_DATA && !rx_edge && since >= end_at
        && rx_bits != 3'h0) |=> st_req && st_fe)
        else $error("partial byte without framing error");
    gear_forward_a: assert property (
        ($rose(RECEIVE_READY_FLAG_OUT) && gear) |-> $past(rx_fwd))
        else $error("gear stored a backward frame");
    overflow_a: assert property (
        (enabled && rx_state == RX_START && !rx_edge && meas >= meas_max
        && RATE_DETECT_ENABLE_IN) |=> RATE_DETECT_OVERFLOW_OUT)
        else $error("overflow flag not set");
    reply_held_a: assert property (
        (gear && wait_on && wait_cnt != 8'h00 && tsr_loaded
        && !TRANSMIT_EMPTY_FLUSH_IN)
        |=> !SHIFT_EMPTY_FLAG_OUT && tx_state == TX_IDLE)
        else $error("gear reply left before wait");

    forward_seen_c: cover property (take && ctrl && rx_fwd);
    framing_seen_c: cover property (take && st_fe);
    reply_sent_c: cover property (gear && tx_go);
    back_to_back_c: cover property (
        tx_state == TX_DATA && tick && half && tx_bits == 3'h7 && hold_full);
endmodule

/* logic/manchester_pkg.sv */
package manchester_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

/* logic/manchester_regs.svh */
`ifndef MANCHESTER_REGS_SVH
`define MANCHESTER_REGS_SVH
// What this block does
// - Every bit has a mid-bit transition; boundary edge only between equal bits.
// - Half bit is 416.7 us, full bit 833.3 us; waits count half bits.
// - Baud divisor is set for 1200 baud in both roles.
// - Bytes go MSB first; forward frame is control byte plus one or two.
// - Receive rate from baud divisor, or from measured start-bit low period.
// - Start-bit measurement counter overflow sets the rate overflow flag.
// - Bits after start are data; stream ends on a missing mid-bit transition.
// - Frame ends with one, one and a half or two idle stop bits by stop select; a byte is stored at its eighth mid-bit transition.
// - An invalid stop bit stores a zero byte with framing error.
// - A missing mid-bit transition inside a byte stores it with framing error.
// - Mode 1000 is controller, 1001 is gear; both enables must be set.
// - Stop select 10 gives two stop bits; line idles through stop halves.
// - Controller idles the frame-wait count after stops; held bytes go after.
// - A backward frame restarts the controller wait timer after its stop bits.
// - Transmit flush empties shifter and buffer outside start and data bits; next byte waits its turn.
// - Controller marks frames starting after threshold idle as forward frames.
// - Gear stores only frames after idle above threshold; others dropped.
// - Gear forward frame end starts wait; reply held, shift empty low.
// - Gear reply written after wait expires waits for next forward frame.
`define MODE_CONTROLLER 4'h8
`define MODE_GEAR 4'h9
`define STOP_TWO 2'h2
`define CLK_PERIOD_NS 40
`define HALF_BIT_NS 416700
`define BIT_NS 833300
`define HALF_BIT_CYCLES ((`HALF_BIT_NS) / (`CLK_PERIOD_NS))
`define NULL_BYTE 8'h00
`define IDLE_SATURATED 8'hFF
`endif

/* test/bus_node.sv */
module bus_node
(
    // Clock
    input wire logic clk_in,
    // Bus line towards the block, idle high
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ns;

    int half = 32;

    initial line_out = 1'b1;

    // Drive one level for a number of half bits
    task automatic hold(input logic lvl, input int n);
        line_out <= lvl;
        repeat (n * half) @(posedge clk_in);
    endtask

    // Send the top nbits of d, start low for lo cycles, then idle
    task automatic send(input logic [7:0] d, input int nbits, input int lo);
        line_out <= 1'b0;
        repeat (lo) @(posedge clk_in);
        hold(1'b1, 1);
        for (int k = 7; k > 7 - nbits; k--)
        begin
            hold(!d[k], 1);
            hold(d[k], 1);
        end
        hold(1'b1, 6);
    endtask
endmodule

/* test/testbench.sv */
module testbench
    import manchester_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] mode = 4'h8;
    logic tx_en = 1'b1;
    logic rx_en = 1'b1;
    logic rate_en = 1'b0;
    logic [7:0] wait_hb = 8'h02;
    logic [7:0] thr_hb = 8'h18;
    logic [7:0] tx_data = 8'h00;
    logic tx_write = 1'b0;
    logic rx_read = 1'b0;
    logic flush = 1'b0;
    logic tx_ready, shift_empty, rx_ready, frame_err, fwd_mark, rate_ovf;
    logic rx_pin, tx_pin;
    logic [7:0] rx_data, a, c, e;
    logic [15:0] v;
    logic [31:0] seed = 32'h7CC8;
    int bad_count = 0;
    int num_checks = 0;

    always #20 clk = ~clk;

    lighting_manchester_uart #(.HALFBIT_CYCLES(16'h0040)) DUT (
        .CLK_IN(clk), .RST_N_IN(rst_n), .MODE_IN(mode),
        .TRANSMITTER_ENABLE_IN(tx_en), .RECEIVER_ENABLE_IN(rx_en),
        .STOP_BIT_SELECT_IN(2'h2), .TRANSMIT_POLARITY_IN(1'b0),
        .RECEIVE_POLARITY_IN(1'b0), .RATE_DETECT_ENABLE_IN(rate_en),
        .BAUD_DIVISOR_IN(16'h001F), .FRAME_WAIT_HALFBITS_IN(wait_hb),
        .FORWARD_THRESHOLD_HALFBITS_IN(thr_hb),
        .TRANSMIT_BUFFER_IN(tx_data), .TRANSMIT_WRITE_IN(tx_write),
        .TRANSMIT_EMPTY_FLUSH_IN(flush), .TRANSMIT_READY_FLAG_OUT(tx_ready),
        .SHIFT_EMPTY_FLAG_OUT(shift_empty), .RECEIVE_READ_IN(rx_read),
        .RECEIVE_BUFFER_OUT(rx_data), .RECEIVE_READY_FLAG_OUT(rx_ready),
        .FRAMING_ERROR_FLAG_OUT(frame_err),
        .FORWARD_FRAME_MARKER_OUT(fwd_mark),
        .RATE_DETECT_OVERFLOW_OUT(rate_ovf),
        .RX_PIN_IN(rx_pin), .TX_PIN_OUT(tx_pin));

    bus_node node (.clk_in(clk), .line_out(rx_pin));

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // Compare and count
    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One write strobe
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        tx_data <= d;
        tx_write <= 1'b1;
        @(posedge clk);
        tx_write <= 1'b0;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (tx_ready !== 1'b1 && n < 100);
    endtask

    task automatic read_pulse();
        @(posedge clk);
        rx_read <= 1'b1;
        @(posedge clk);
        rx_read <= 1'b0;
        @(negedge clk);
    endtask

    // Decode nbits from the pin: second half of each bit is its value
    task automatic decode(input int nbits, output logic [15:0] val);
        int n;
        n = 0;
        val = '0;
        while (tx_pin !== 1'b0 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
        repeat (112) @(posedge clk);
        for (int k = 0; k < nbits; k++)
        begin
            val = {val[14:0], tx_pin};
            repeat (64) @(posedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        final_report();
    end

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("tx idle", tx_pin, 1'b1);
        check("shift empty", shift_empty, 1'b1);
        // Controller two-byte forward frame, second byte all zeros
        a = rnd();
        fork
            decode(16, v);
            begin
                wr(a);
                wait_ready();
                wr(8'h00);
            end
        join
        check("forward frame", v, {a, 8'h00});
        $display("test controller transmit done");
        // Forward then backward frame received
        repeat (1024) @(posedge clk);
        c = rnd();
        e = rnd();
        node.send(c, 8, 32);
        check("rx byte", rx_data, c);
        check("rx error", frame_err, 1'b0);
        check("forward mark", fwd_mark, 1'b1);
        read_pulse();
        check("rx read", rx_ready, 1'b0);
        repeat (320) @(posedge clk);
        node.send(e, 8, 32);
        check("rx backward", rx_data, e);
        check("backward mark", fwd_mark, 1'b0);
        $display("test controller receive done");
        // Truncated frame, then measured-rate frame, then overflow
        node.send(c, 5, 32);
        check("short frame", frame_err, 1'b1);
        check("short data", rx_data, {3'h0, c[7:3]});
        rate_en <= 1'b1;
        node.send(e, 8, 32);
        check("rate byte", rx_data, e);
        check("no overflow", rate_ovf, 1'b0);
        node.send(c, 8, 200);
        check("overflow", rate_ovf, 1'b1);
        $display("test rate detect done");
        // Gear role: forward frame stored, delayed reply
        rate_en <= 1'b0;
        tx_en <= 1'b0;
        rx_en <= 1'b0;
        repeat (4) @(posedge clk);
        mode <= 4'h9;
        wait_hb <= 8'h06;
        tx_en <= 1'b1;
        rx_en <= 1'b1;
        repeat (1024) @(posedge clk);
        a = rnd();
        node.send(a, 8, 32);
        check("gear rx", rx_data, a);
        read_pulse();
        c = rnd();
        fork
            decode(8, v);
            begin
                wr(c);
                repeat (3) @(negedge clk);
                check("reply held", shift_empty, 1'b0);
            end
        join
        check("gear reply", v, c);
        repeat (64) @(posedge clk);
        node.send(rnd(), 8, 32);
        check("backward dropped", rx_ready, 1'b0);
        // Late reply is held with no wait running, then flushed
        wr(rnd());
        repeat (200) @(negedge clk);
        check("late reply held", shift_empty, 1'b0);
        check("late reply line", tx_pin, 1'b1);
        @(posedge clk);
        flush <= 1'b1;
        @(posedge clk);
        flush <= 1'b0;
        @(negedge clk);
        check("flush shifter", shift_empty, 1'b1);
        check("flush buffer", tx_ready, 1'b1);
        $display("test gear done");
        final_report();
    end
endmodule
